// File: hw/iew_pkg.sv
// Purpose: constants and types for the interrupt enable and idle/power-down controller
// Assumes: one 250 MHz core clock; state phases come from a phase counter in the block
// Notes:   register indices are word indices; byte address is four times the index
//
// Summary of operation
// - six sources: two lines, three timers, serial
// - each source has its own enable bit
// - bit 7 global enable gates all sources
// - enable bits 5..0: t2, serial, t1, x1, t0, x0
// - timer 2 request is overflow OR external flag, external flag only outside up/down mode
// - timer 2 flags cleared only by software
// - timer 0/1 flags set S5P2, sampled next cycle
// - clock-out rollovers raise no interrupt
// - idle stops core, peripherals keep running
// - idle ends on enabled interrupt or reset
// - reset wake blocks RAM for two cycles
// - power-down stops oscillator, keeps state
// - power-down exits only by hardware reset
// - idle strobes high, power-down strobes low
// - idle external memory: port 2 drives address
// - overflow and falling-edge set timer 2 flags
// - up/down mode external flag toggles, no interrupt
package iew_pkg;
    // register indices
    localparam logic [3:0] IEW_REG_IRQ_ENABLE = 4'h0;  // interrupt_enable
    localparam logic [3:0] IEW_REG_FLAGS      = 4'h1;  // source flags, write one to clear timer 2 flags
    localparam logic [3:0] IEW_REG_T2_CTRL    = 4'h2;  // timer 2 mode bits
    localparam logic [3:0] IEW_REG_POWER      = 4'h3;  // idle / power-down request and status
    localparam logic [3:0] IEW_REG_PENDING    = 4'h4;  // qualified requests
    // interrupt_enable bit positions
    localparam int IEW_BIT_GLOBAL = 7;
    localparam int IEW_BIT_RSVD   = 6;
    localparam int IEW_BIT_T2     = 5;
    localparam int IEW_BIT_SER    = 4;
    localparam int IEW_BIT_T1     = 3;
    localparam int IEW_BIT_X1     = 2;
    localparam int IEW_BIT_T0     = 1;
    localparam int IEW_BIT_X0     = 0;
    // flags register positions
    localparam int IEW_FLG_T2_OVF = 6;
    localparam int IEW_FLG_T2_EXT = 7;
    // timer 2 control positions
    localparam int IEW_T2C_UPDOWN = 0;
    localparam int IEW_T2C_BAUD   = 1;
    localparam int IEW_T2C_CLKOUT = 2;
    localparam int IEW_T2C_EXTEN  = 3;
    // power register positions
    localparam int IEW_PWR_IDLE   = 0;
    localparam int IEW_PWR_PDOWN  = 1;
    localparam int IEW_PWR_EXTMEM = 2;
    localparam logic [7:0] IEW_IE_RESET   = 8'h00;
    localparam logic [7:0] IEW_RSVD_MASK  = 8'h40;
    // machine cycle: 6 states of 2 phases, one clock per phase
    localparam int IEW_PHASES_PER_CYCLE = 12;
    localparam logic [3:0] IEW_PH_S2P2  = 4'h3;
    localparam logic [3:0] IEW_PH_S5P2  = 4'h9;
    localparam logic [3:0] IEW_PH_LAST  = 4'hb;
    localparam int IEW_WAKE_CYCLES = 2;

    typedef enum logic [2:0] {
        IEW_RUN   = 3'b001,
        IEW_IDLE  = 3'b010,
        IEW_PDOWN = 3'b100
    } iew_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } iew_bus_t;

    typedef struct packed {
        logic addr_strobe;    // address latch strobe
        logic prog_store_strobe;
        logic port0_float;
        logic port2_addr;     // port 2 keeps driving the address
    } iew_pins_t;
endpackage : iew_pkg

// File: hw/iew_ctrl.sv
// Purpose: interrupt enable, timer-2 flag logic, idle and power-down control
// Assumes: source events are one-clock pulses synchronous to core_clk_in
// Notes:   flags are sticky; set beats clear in the same cycle
`timescale 1ns/10ps
module iew_ctrl
    import iew_pkg::*;
#(
    parameter int WAKE_CYCLES = IEW_WAKE_CYCLES
) (
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       ext_irq_line_zero_in,   // flag level from line 0 logic
    input  wire logic       ext_irq_line_one_in,
    input  wire logic       timer0_overflow_in,     // overflow event pulse
    input  wire logic       timer1_overflow_in,
    input  wire logic       timer2_overflow_in,
    input  wire logic       timer2_ext_fall_in,     // falling edge seen on timer2_ext_input
    input  wire logic       serial_irq_in,
    input  wire logic       hw_reset_req_in,        // pin reset request, in idle or while running
    output logic      [5:0] irq_req_out,
    output logic            irq_any_out,
    output logic            core_halt_out,
    output logic            osc_stop_out,
    output logic            ram_block_out,
    output logic            internal_reset_out,
    output iew_pins_t       pins_out
);
    // elaboration check: the wake counter is four bits wide
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 15) begin : g_bad_wake
        $error("WAKE_CYCLES out of range");
    end

    logic [7:0] interrupt_enable_q;
    logic [3:0] t2_ctrl_q;
    logic       extmem_q;
    logic [3:0] phase_q;
    logic       t0_pend_q, t1_pend_q, t2_pend_q;
    logic       timer0_overflow_flag_q, timer1_overflow_flag_q;
    logic       timer2_overflow_flag_q, timer2_external_flag_q;
    logic [5:0] flags;
    logic [5:0] qual;
    iew_mode_t  mode_q;
    logic [3:0] wake_cnt_q;
    logic       wr_ie, wr_flg, wr_t2c, wr_pwr;
    logic       t2_quiet;

    assign wr_ie  = reg_wr_in && reg_addr_in == IEW_REG_IRQ_ENABLE;
    assign wr_flg = reg_wr_in && reg_addr_in == IEW_REG_FLAGS;
    assign wr_t2c = reg_wr_in && reg_addr_in == IEW_REG_T2_CTRL;
    assign wr_pwr = reg_wr_in && reg_addr_in == IEW_REG_POWER;
    assign t2_quiet = t2_ctrl_q[IEW_T2C_BAUD] | t2_ctrl_q[IEW_T2C_CLKOUT];

    // enable register; reserved bit kept zero by hardware
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            interrupt_enable_q <= IEW_IE_RESET;
        end else if (wr_ie) begin
            interrupt_enable_q <= reg_wdata_in & ~IEW_RSVD_MASK;
        end
    end

    // timer 2 mode and memory configuration
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            t2_ctrl_q <= 4'h0;
            extmem_q  <= 1'b0;
        end else begin
            if (wr_t2c) begin
                t2_ctrl_q <= reg_wdata_in[3:0];
            end
            if (wr_pwr) begin
                extmem_q <= reg_wdata_in[IEW_PWR_EXTMEM];
            end
        end
    end

    // machine cycle phase counter, stopped in power-down
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_q <= 4'h0;
        end else if (mode_q != IEW_PDOWN) begin
            phase_q <= (phase_q == IEW_PH_LAST) ? 4'h0 : phase_q + 4'h1;
        end
    end

    // hold overflow events until their setting phase
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            t0_pend_q <= 1'b0;
            t1_pend_q <= 1'b0;
            t2_pend_q <= 1'b0;
        end else begin
            t0_pend_q <= timer0_overflow_in | (t0_pend_q & phase_q != IEW_PH_S5P2);
            t1_pend_q <= timer1_overflow_in | (t1_pend_q & phase_q != IEW_PH_S5P2);
            t2_pend_q <= timer2_overflow_in | (t2_pend_q & phase_q != IEW_PH_S2P2);
        end
    end

    // timer 0/1 flags set at S5P2, cleared by write-one
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            timer0_overflow_flag_q <= 1'b0;
            timer1_overflow_flag_q <= 1'b0;
        end else begin
            if (t0_pend_q && phase_q == IEW_PH_S5P2) begin
                timer0_overflow_flag_q <= 1'b1;
            end else if (wr_flg && reg_wdata_in[IEW_BIT_T0]) begin
                timer0_overflow_flag_q <= 1'b0;
            end
            if (t1_pend_q && phase_q == IEW_PH_S5P2) begin
                timer1_overflow_flag_q <= 1'b1;
            end else if (wr_flg && reg_wdata_in[IEW_BIT_T1]) begin
                timer1_overflow_flag_q <= 1'b0;
            end
        end
    end

    // timer 2 flags: overflow set at S2P2, external set on the falling edge; never cleared by vectoring
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            timer2_overflow_flag_q <= 1'b0;
            timer2_external_flag_q <= 1'b0;
        end else begin
            if (t2_pend_q && phase_q == IEW_PH_S2P2 && !t2_quiet) begin
                timer2_overflow_flag_q <= 1'b1;
            end else if (wr_flg && reg_wdata_in[IEW_FLG_T2_OVF]) begin
                timer2_overflow_flag_q <= 1'b0;
            end
            if (t2_ctrl_q[IEW_T2C_UPDOWN]) begin
                if (t2_pend_q && phase_q == IEW_PH_S2P2) begin
                    timer2_external_flag_q <= ~timer2_external_flag_q;
                end else if (wr_flg && reg_wdata_in[IEW_FLG_T2_EXT]) begin
                    timer2_external_flag_q <= 1'b0;
                end
            end else if (timer2_ext_fall_in && t2_ctrl_q[IEW_T2C_EXTEN]) begin
                timer2_external_flag_q <= 1'b1;
            end else if (wr_flg && reg_wdata_in[IEW_FLG_T2_EXT]) begin
                timer2_external_flag_q <= 1'b0;
            end
        end
    end

    // six sources gathered in enable-bit order
    always_comb begin
        flags = '0;
        flags[IEW_BIT_X0]  = ext_irq_line_zero_in;
        flags[IEW_BIT_T0]  = timer0_overflow_flag_q;
        flags[IEW_BIT_X1]  = ext_irq_line_one_in;
        flags[IEW_BIT_T1]  = timer1_overflow_flag_q;
        flags[IEW_BIT_SER] = serial_irq_in;
        flags[IEW_BIT_T2]  = timer2_overflow_flag_q |
                             (timer2_external_flag_q & ~t2_ctrl_q[IEW_T2C_UPDOWN]);
    end

    // qualified requests
    assign qual = flags & interrupt_enable_q[5:0] & {6{interrupt_enable_q[IEW_BIT_GLOBAL]}};

    // request outputs registered
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_req_out <= 6'h00;
            irq_any_out <= 1'b0;
        end else begin
            irq_req_out <= qual;
            irq_any_out <= |qual;
        end
    end

    // power mode machine
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_q <= IEW_RUN;
        end else begin
            case (mode_q)
                IEW_RUN: begin
                    if (wr_pwr && reg_wdata_in[IEW_PWR_PDOWN]) begin
                        mode_q <= IEW_PDOWN;
                    end else if (wr_pwr && reg_wdata_in[IEW_PWR_IDLE]) begin
                        mode_q <= IEW_IDLE;
                    end
                end
                IEW_IDLE: begin
                    if (|qual || hw_reset_req_in) begin
                        mode_q <= IEW_RUN;
                    end
                end
                IEW_PDOWN: begin
                    mode_q <= IEW_PDOWN;
                end
                default: begin
                    mode_q <= IEW_RUN;
                end
            endcase
        end
    end

    // reset wake window counted in machine cycles
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_cnt_q <= 4'h0;
        end else if (mode_q == IEW_IDLE && hw_reset_req_in) begin
            wake_cnt_q <= 4'(WAKE_CYCLES);
        end else if (wake_cnt_q != 4'h0 && phase_q == IEW_PH_LAST) begin
            wake_cnt_q <= wake_cnt_q - 4'h1;
        end
    end

    // reset pulse once the wake window closes
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            internal_reset_out <= 1'b0;
        end else begin
            internal_reset_out <= (wake_cnt_q == 4'h1 && phase_q == IEW_PH_LAST) ||
                                  (hw_reset_req_in && mode_q == IEW_RUN && wake_cnt_q == 4'h0);
        end
    end

    // core, oscillator, RAM and pin controls
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            core_halt_out  <= 1'b0;
            osc_stop_out   <= 1'b0;
            ram_block_out  <= 1'b0;
            pins_out       <= '0;
        end else begin
            core_halt_out  <= mode_q != IEW_RUN;
            osc_stop_out   <= mode_q == IEW_PDOWN;
            ram_block_out  <= wake_cnt_q != 4'h0;
            pins_out.addr_strobe       <= mode_q != IEW_PDOWN;
            pins_out.prog_store_strobe <= mode_q != IEW_PDOWN;
            pins_out.port0_float       <= mode_q != IEW_RUN && extmem_q;
            pins_out.port2_addr        <= mode_q != IEW_PDOWN && extmem_q;
        end
    end

    // register read, one cycle after the strobe
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                IEW_REG_IRQ_ENABLE: reg_rdata_out <= interrupt_enable_q;
                IEW_REG_FLAGS:      reg_rdata_out <= {timer2_external_flag_q, timer2_overflow_flag_q, flags[5:0]};
                IEW_REG_T2_CTRL:    reg_rdata_out <= {4'h0, t2_ctrl_q};
                IEW_REG_POWER:      reg_rdata_out <= {5'h00, extmem_q, mode_q == IEW_PDOWN, mode_q == IEW_IDLE};
                IEW_REG_PENDING:    reg_rdata_out <= {2'h0, qual};
                default:            reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule : iew_ctrl

// File: tb/iew_monitor.sv
// Purpose: port checker for the interrupt enable and idle controller
// Assumes: bound onto iew_ctrl from the bench top file
// Notes:   watches design outputs against their causes
`timescale 1ns/10ps
module iew_monitor
    import iew_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       arst_n_in,
    input wire logic       reg_rd_in,
    input wire logic       ext_irq_line_zero_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [5:0] irq_req_out,
    input wire logic       irq_any_out,
    input wire logic       core_halt_out,
    input wire logic       osc_stop_out,
    input wire logic       ram_block_out,
    input wire logic       internal_reset_out,
    input wire iew_pins_t  pins_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    // halted in idle while a qualified request is pending
    sequence s_idle_req;
        core_halt_out && !osc_stop_out && irq_any_out;
    endsequence
    // ram stays blocked for a good part of the wake window
    sequence s_blocked;
        ram_block_out [*8];
    endsequence
    AST_ANY_OR: assert property (irq_any_out == (|irq_req_out)) else $error("any differs from OR");
    AST_RDATA_ZERO: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("stray rdata");
    AST_X0_CAUSE: assert property (irq_req_out[0] |-> $past(ext_irq_line_zero_in)) else $error("x0 no flag");
    AST_IDLE_PINS: assert property (core_halt_out && !osc_stop_out && $past(core_halt_out)
        |-> pins_out.addr_strobe && pins_out.prog_store_strobe) else $error("idle strobes");
    AST_PD_PINS: assert property (osc_stop_out && $past(osc_stop_out)
        |-> !pins_out.addr_strobe && !pins_out.prog_store_strobe) else $error("pd strobes");
    AST_PD_HOLD: assert property (osc_stop_out |=> osc_stop_out) else $error("pd left");
    AST_WAKE: assert property (s_idle_req |-> ##[0:24] !core_halt_out) else $error("no wake");
    AST_RAM_HOLD: assert property ($rose(ram_block_out) |-> s_blocked) else $error("ram block short");
    // internal reset takes over in the last cycle of the wake window; a held pin keeps it high
    AST_RST_AFTER: assert property ($fell(ram_block_out) |-> $past(internal_reset_out))
        else $error("reset late");
endmodule : iew_monitor

// File: tb/iew_core_model.sv
// Purpose: behavioural core that takes vectors from the controller
// Assumes: requests are levels held until software clears the flag
// Notes:   lowest pending source wins; 7 means no vector taken
`timescale 1ns/10ps
module iew_core_model (
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [5:0] irq_req_in,
    input  wire logic       halt_in,
    output logic      [2:0] vec_out
);
    // pick one of the six vectors while the core runs
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vec_out <= 3'h7;
        end else if (!halt_in) begin
            vec_out <= 3'h7;
            for (int i = 5; i >= 0; i--) begin
                if (irq_req_in[i]) begin
                    vec_out <= 3'(i);
                end
            end
        end
    end
endmodule : iew_core_model

// File: tb/tb_top.sv
// Purpose: self-checking bench for the interrupt enable and idle controller
// Assumes: 250 MHz clock, asynchronous active-low reset
// Notes:   registers reached through the plain strobe port
`timescale 1ns/10ps
module tb_top;
    import iew_pkg::*;
    logic       core_clk_in, arst_n_in, reg_wr_in, reg_rd_in, hw_reset_req_in, serial_irq_in;
    logic       ext_irq_line_zero_in, ext_irq_line_one_in, timer2_ext_fall_in;
    logic       timer0_overflow_in, timer1_overflow_in, timer2_overflow_in;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic [5:0] irq_req_out;
    logic       irq_any_out, core_halt_out, osc_stop_out, ram_block_out, internal_reset_out, rb, ir;
    iew_pins_t  pins_out;
    logic [2:0] vec;
    int         n_mismatch, n_compared, cyc, d0, d2, k;

    iew_ctrl #(
        .WAKE_CYCLES          (IEW_WAKE_CYCLES)
    ) dut_u (
        .core_clk_in          (core_clk_in),
        .arst_n_in            (arst_n_in),
        .reg_wr_in            (reg_wr_in),
        .reg_rd_in            (reg_rd_in),
        .reg_addr_in          (reg_addr_in),
        .reg_wdata_in         (reg_wdata_in),
        .reg_rdata_out        (reg_rdata_out),
        .ext_irq_line_zero_in (ext_irq_line_zero_in),
        .ext_irq_line_one_in  (ext_irq_line_one_in),
        .timer0_overflow_in   (timer0_overflow_in),
        .timer1_overflow_in   (timer1_overflow_in),
        .timer2_overflow_in   (timer2_overflow_in),
        .timer2_ext_fall_in   (timer2_ext_fall_in),
        .serial_irq_in        (serial_irq_in),
        .hw_reset_req_in      (hw_reset_req_in),
        .irq_req_out          (irq_req_out),
        .irq_any_out          (irq_any_out),
        .core_halt_out        (core_halt_out),
        .osc_stop_out         (osc_stop_out),
        .ram_block_out        (ram_block_out),
        .internal_reset_out   (internal_reset_out),
        .pins_out             (pins_out)
    );
    iew_core_model core_u (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .irq_req_in  (irq_req_out),
        .halt_in     (core_halt_out),
        .vec_out     (vec)
    );

    // clock source
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    // hang guard
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : wt
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(nm, reg_rdata_out, exp);
    endtask : rd
    task automatic ck_irq(input logic [5:0] exp);
        wt(3);
        chk("irq", {2'h0, irq_req_out}, {2'h0, exp});
    endtask : ck_irq

    // main sequence
    initial begin
        {reg_wr_in, reg_rd_in, hw_reset_req_in, serial_irq_in, ext_irq_line_zero_in} = '0;
        {ext_irq_line_one_in, timer2_ext_fall_in, timer0_overflow_in, timer1_overflow_in} = '0;
        timer2_overflow_in = 1'b0;
        reg_addr_in = 4'h0;
        reg_wdata_in = 8'h00;
        {n_mismatch, n_compared} = '0;
        arst_n_in = 1'b0;
        repeat (3) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        rd(IEW_REG_IRQ_ENABLE, IEW_IE_RESET, "ie reset");
        wr(IEW_REG_IRQ_ENABLE, 8'hff);
        rd(IEW_REG_IRQ_ENABLE, 8'hbf, "ie bit6");
        rd(4'hf, 8'h00, "unmapped");
        @(posedge core_clk_in);
        {ext_irq_line_zero_in, ext_irq_line_one_in, serial_irq_in} <= 3'h7;
        wr(IEW_REG_IRQ_ENABLE, 8'h15);
        ck_irq(6'h00);
        for (k = 0; k < 5; k += 2) begin
            wr(IEW_REG_IRQ_ENABLE, 8'h80 | (8'h01 << k));
            ck_irq(6'h01 << k);
            chk("vector", {5'h0, vec}, 8'(k));
        end
        wr(IEW_REG_IRQ_ENABLE, 8'h95);
        ck_irq(6'h15);
        rd(IEW_REG_PENDING, 8'h15, "pending");
        {ext_irq_line_zero_in, ext_irq_line_one_in, serial_irq_in} <= 3'h0;
        // timer overflows: flag phases differ by half a machine cycle
        wr(IEW_REG_IRQ_ENABLE, 8'haa);
        {timer0_overflow_in, timer1_overflow_in, timer2_overflow_in} <= 3'h7;
        @(posedge core_clk_in);
        {timer0_overflow_in, timer1_overflow_in, timer2_overflow_in} <= 3'h0;
        d0 = 0;
        d2 = 0;
        for (k = 1; k < 40; k++) begin
            wt(1);
            if (irq_req_out[1] && d0 == 0) d0 = k;
            if (irq_req_out[5] && d2 == 0) d2 = k;
        end
        chk("phase gap", 8'((d0 - d2 + 12) % 12), 8'h06);
        chk("timers", {2'h0, irq_req_out}, 8'h2a);
        wr(IEW_REG_FLAGS, 8'h4a);
        ck_irq(6'h00);
        wr(IEW_REG_T2_CTRL, 8'h08);
        timer2_ext_fall_in <= 1'b1;
        @(posedge core_clk_in);
        timer2_ext_fall_in <= 1'b0;
        ck_irq(6'h20);
        wr(IEW_REG_FLAGS, 8'h80);
        ck_irq(6'h00);
        // baud, clock-out and up/down rollovers
        for (k = 1; k < 4; k++) begin
            wr(IEW_REG_T2_CTRL, (k == 3) ? 8'h09 : 8'(k * 2));
            timer2_overflow_in <= 1'b1;
            @(posedge core_clk_in);
            timer2_overflow_in <= 1'b0;
            wt(30);
            if (k == 3) wr(IEW_REG_FLAGS, 8'h40);
            ck_irq(6'h00);
        end
        rd(IEW_REG_FLAGS, 8'h80, "t2 toggle");
        wr(IEW_REG_FLAGS, 8'h80);
        // idle with external memory, then wake by interrupt
        wr(IEW_REG_T2_CTRL, 8'h00);
        wr(IEW_REG_IRQ_ENABLE, 8'h81);
        wr(IEW_REG_POWER, 8'h05);
        wt(3);
        chk("halt", {7'h0, core_halt_out}, 8'h01);
        chk("idle pins", {4'h0, pins_out}, 8'h0f);
        rd(IEW_REG_POWER, 8'h05, "idle status");
        ext_irq_line_zero_in <= 1'b1;
        wt(30);
        chk("woken", {7'h0, core_halt_out}, 8'h00);
        ext_irq_line_zero_in <= 1'b0;
        // idle left by the reset pin
        wr(IEW_REG_POWER, 8'h01);
        wt(3);
        hw_reset_req_in <= 1'b1;
        {rb, ir} = 2'b00;
        for (k = 0; k < 60; k++) begin
            wt(1);
            rb |= ram_block_out;
            ir |= internal_reset_out;
        end
        chk("ram block", {6'h0, rb, ir}, 8'h03);
        hw_reset_req_in <= 1'b0;
        // power-down holds until the hardware reset
        wr(IEW_REG_IRQ_ENABLE, 8'h81);
        wr(IEW_REG_POWER, 8'h06);
        wt(3);
        chk("pd pins", {3'h0, osc_stop_out, pins_out}, 8'h12);
        ext_irq_line_zero_in <= 1'b1;
        wt(30);
        chk("pd held", {7'h0, osc_stop_out}, 8'h01);
        arst_n_in <= 1'b0;
        wt(3);
        arst_n_in <= 1'b1;
        wt(2);
        chk("pd exit", {7'h0, osc_stop_out}, 8'h00);
        rd(IEW_REG_IRQ_ENABLE, IEW_IE_RESET, "ie after reset");
        close_out();
    end
endmodule : tb_top

bind iew_ctrl iew_monitor mon_u (
    .core_clk_in          (core_clk_in),
    .arst_n_in            (arst_n_in),
    .reg_rd_in            (reg_rd_in),
    .ext_irq_line_zero_in (ext_irq_line_zero_in),
    .reg_rdata_out        (reg_rdata_out),
    .irq_req_out          (irq_req_out),
    .irq_any_out          (irq_any_out),
    .core_halt_out        (core_halt_out),
    .osc_stop_out         (osc_stop_out),
    .ram_block_out        (ram_block_out),
    .internal_reset_out   (internal_reset_out),
    .pins_out             (pins_out)
);
